// ### verilog/mdo_pkg.sv
// Constants, register map and types of the motor drive operation block
package mdo_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = 4;
  // Speeds, loads and angles
  localparam int SPD_W = 13;
  localparam logic [12:0] RATED_RPM = 13'h0bb8;
  localparam logic [8:0] OVL_SMALL_PCT = 9'h0b4;
  localparam logic [8:0] OVL_LARGE_PCT = 9'h096;
  localparam logic [6:0] KEEP_TRQ_PCT = 7'h32;
  localparam logic [7:0] KEEP_ANGLE_DEG = 8'h0f;
  localparam logic [8:0] VA_MIN = 9'h001;
  localparam logic [8:0] VA_MAX = 9'h190;
  localparam logic [8:0] VA_DEF = 9'h0c8;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ACC = 8'h04;
  localparam logic [7:0] A_DEC = 8'h08;
  localparam logic [7:0] A_VA = 8'h0c;
  localparam logic [7:0] A_OVL = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_SPD = 8'h18;
  localparam logic [7:0] A_TAB_LO = 8'h20;
  localparam logic [7:0] A_TAB_HI = 8'h3c;
  localparam logic [1:0] TAB_SPEED = 2'h2;
  localparam logic [1:0] TAB_TORQUE = 2'h3;
  // Control register fields
  localparam int C_PREV = 0;
  localparam int C_KEEP = 1;
  localparam int C_UNIT = 2;
  localparam int C_BIGM = 3;
  localparam int C_FLT = 4;
  localparam int C_MODE = 8;
  localparam int C_CFG = 16;
  localparam int C_ACLR = 17;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL_STORE = 32'h0000_073f;
  // Reset values of times (ms) and table entries
  localparam logic [15:0] ACC_DEF = 16'h01f4;
  localparam logic [15:0] OVL_DEF = 16'h1388;
  localparam logic [12:0] SPD_DEF = 13'h0000;
  localparam logic [6:0] TRQ_DEF = 7'h64;
  // Filter codes and shifts
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_ONE = 2'h1;
  localparam int FLT_ONE_SH = 2;
  localparam int FLT_TWO_SH = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Run input schemes
  typedef enum logic [2:0] {
    MD_2W1 = 3'h0, MD_3W1 = 3'h1, MD_2W2 = 3'h2,
    MD_2W3 = 3'h3, MD_3W2 = 3'h4, MD_3W3 = 3'h5
  } mdo_mode_e;
  // Run states
  typedef enum logic [3:0] {
    ST_INHIBIT = 4'b0001, ST_IDLE = 4'b0010, ST_RUN = 4'b0100, ST_DECEL = 4'b1000
  } mdo_state_e;
endpackage

// ### verilog/mdo_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mdo_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and clean levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  genvar gi;
  for (gi = 0; gi < W; gi++) begin : g_bit
    logic [2:0] stg_reg;
    logic [2:0] stg_next;
    logic q_reg;
    logic q_next;
    // Shift in; accept a change once stages two and three agree
    always_comb begin
      stg_next = {stg_reg[1:0], pin[gi]};
      q_next = (stg_reg[1] == stg_reg[2]) ? stg_reg[2] : q_reg;
    end
    // Registers
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stg_reg <= 3'h0;
        q_reg <= 1'b0;
      end else begin
        stg_reg <= stg_next;
        q_reg <= q_next;
      end
    end
    assign level[gi] = q_reg;
  end
endmodule // mdo_pin_sync

// ### verilog/mdo_ramp.sv
// Speed ramp generator with impact softening filter
`timescale 1ns/1ps
module mdo_ramp
  import mdo_pkg::*;
#(
  parameter int CYC_PER_MS = mdo_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Ramp control
  input wire logic [12:0] target,
  input wire logic [15:0] acc_time,
  input wire logic [15:0] dec_time,
  input wire logic unit_set,
  input wire logic kill,
  input wire logic [1:0] flt_sel,
  input wire logic ms_tick,
  // Ramp output
  output logic [12:0] speed_out
);
  logic [39:0] acc_reg, acc_next, thr, sum;
  logic [12:0] raw_reg, raw_next, flt_reg, flt_next, span;
  logic signed [13:0] diff, step;
  logic up;
  // Fractional step accumulator: span r/min per time ms
  always_comb begin
    up = target > raw_reg;
    span = (unit_set && target != 13'h0) ? target : RATED_RPM;
    thr = 40'(up ? acc_time : dec_time) * 40'(CYC_PER_MS);
    sum = acc_reg + 40'(span);
    acc_next = sum;
    raw_next = raw_reg;
    if (kill) begin
      acc_next = 40'h0;
      raw_next = 13'h0;
    end else if (raw_reg == target) begin
      acc_next = 40'h0;
    end else if (sum >= thr) begin
      acc_next = sum - thr;
      raw_next = up ? raw_reg + 13'h1 : raw_reg - 13'h1;
    end
  end
  // Softening filter, one update per millisecond
  always_comb begin
    diff = $signed({1'b0, raw_next}) - $signed({1'b0, flt_reg});
    step = (flt_sel == FLT_ONE) ? (diff >>> FLT_ONE_SH) : (diff >>> FLT_TWO_SH);
    flt_next = flt_reg;
    if (kill || flt_sel == FLT_NONE) begin
      flt_next = raw_next;
    end else if (ms_tick) begin
      if (step == 14'sh0 || (diff < 14'sh0 && step == -14'sh1)) begin
        flt_next = raw_next;
      end else begin
        flt_next = 13'(flt_reg + 13'(step));
      end
    end
  end
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 40'h0;
      raw_reg <= 13'h0;
      flt_reg <= 13'h0;
    end else begin
      acc_reg <= acc_next;
      raw_reg <= raw_next;
      flt_reg <= flt_next;
    end
  end
  assign speed_out = flt_reg;
endmodule // mdo_ramp

// ### verilog/mdo_motor_ctrl.sv
// Motor drive operation control with AXI4-Lite register slave
`timescale 1ns/1ps
module mdo_motor_ctrl #(
  parameter int CYC_PER_MS = mdo_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Run input pins
  input wire logic forward_run_input,
  input wire logic backward_run_input,
  input wire logic rotation_direction_input,
  input wire logic main_power_on,
  input wire logic op_select_valid,
  input wire logic [1:0] op_select,
  // Motor feedback
  input wire logic [12:0] motor_speed,
  input wire logic [8:0] load_factor_pct,
  input wire logic [7:0] shaft_offset_deg,
  // Motor and brake drive
  output logic [12:0] speed_command,
  output logic rotate_ccw,
  output logic motor_run,
  output logic hold_torque_en,
  output logic [6:0] hold_torque_limit,
  output logic brake_release,
  output logic speed_attained_output,
  output logic overload_alarm
);
  import mdo_pkg::*;

  logic f_in, b_in, d_in, pwr, osv;
  logic [1:0] osel;
  logic [12:0] ramp_spd;
  // Pin synchronisers
  mdo_pin_sync #(.W(7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({op_select, op_select_valid, main_power_on, rotation_direction_input,
          backward_run_input, forward_run_input}),
    .level({osel, osv, pwr, d_in, b_in, f_in})
  );

  // Register state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [15:0] acc_reg, acc_next, dec_reg, dec_next, ovl_reg, ovl_next;
  logic [8:0] va_reg, va_next;
  logic [12:0] spd_tab_reg [4];
  logic [12:0] spd_tab_next [4];
  logic [6:0] trq_tab_reg [4];
  logic [6:0] trq_tab_next [4];
  logic cfg_pulse, alarm_clr;
  // Bus channel state
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] aw_addr_reg, aw_addr_next, wr_addr;
  logic [31:0] w_data_reg, w_data_next, wr_data, nv, cur_word;
  logic [3:0] w_strb_reg, w_strb_next, wr_strb;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, wr_go;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // Operating state
  mdo_state_e st_reg, st_next;
  logic [2:0] mode_reg, mode_next;
  logic keep_reg, keep_next, dir_reg, dir_next, pwr_reg;
  logic [1:0] flt_reg, flt_next;
  logic [2:0] settle_reg, settle_next;
  logic [31:0] ms_cnt_reg, ms_cnt_next;
  logic [15:0] ovc_reg, ovc_next;
  logic alarm_reg, alarm_next, va_out_reg, va_out_next;
  logic hold_reg, hold_next, brk_reg, brk_next;
  logic [6:0] hlim_reg, hlim_next;
  logic ms_tick, run_req, req_dir, kill, any_in, three, zero;
  logic [12:0] set_spd, target, spd_diff;
  logic [6:0] sel_trq;

  // Address map check, shared by read and write
  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a <= A_SPD || (a >= A_TAB_LO && a <= A_TAB_HI));
  endfunction
  // Register word at an address
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      A_CTRL: v = ctrl_reg;
      A_ACC: v = {16'h0, acc_reg};
      A_DEC: v = {16'h0, dec_reg};
      A_VA: v = {23'h0, va_reg};
      A_OVL: v = {16'h0, ovl_reg};
      A_STAT: v = {17'h0, mode_reg, flt_reg, keep_reg, brk_reg, hold_reg, va_out_reg,
                   alarm_reg, dir_reg, st_reg};
      A_SPD: v = {19'h0, motor_speed};
      default: begin
        if (a[5:4] == TAB_SPEED) begin
          v = {19'h0, spd_tab_reg[a[3:2]]};
        end else if (a[5:4] == TAB_TORQUE) begin
          v = {25'h0, trq_tab_reg[a[3:2]]};
        end
      end
    endcase
    return v;
  endfunction
  // Whether a run input scheme is a 3-wire one
  function automatic logic is_3wire(input logic [2:0] m);
    return m == MD_3W1 || m == MD_3W2 || m == MD_3W3;
  endfunction

  // Write channel: address and data taken in either order
  always_comb begin
    wr_addr = aw_got_reg ? aw_addr_reg : awaddr;
    wr_data = w_got_reg ? w_data_reg : wdata;
    wr_strb = w_got_reg ? w_strb_reg : wstrb;
    awready = !aw_got_reg && !bvalid_reg;
    wready = !w_got_reg && !bvalid_reg;
    wr_go = (aw_got_reg || awvalid) && (w_got_reg || wvalid) && !bvalid_reg;
    aw_got_next = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next = w_got_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (wr_go) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (awvalid && awready) begin
        aw_got_next = 1'b1;
        aw_addr_next = awaddr;
      end
      if (wvalid && wready) begin
        w_got_next = 1'b1;
        w_data_next = wdata;
        w_strb_next = wstrb;
      end
      if (bvalid_reg && bready) begin
        bvalid_next = 1'b0;
      end
    end
  end

  // Read channel: one-cycle answer from the register word
  always_comb begin
    arready = !rvalid_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rdata_next = is_mapped(araddr) ? reg_word(araddr) : 32'h0;
      rresp_next = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Register writes with byte strobes
  always_comb begin
    cur_word = reg_word(wr_addr);
    for (int i = 0; i < 4; i++) begin
      nv[i*8 +: 8] = wr_strb[i] ? wr_data[i*8 +: 8] : cur_word[i*8 +: 8];
    end
    ctrl_next = ctrl_reg;
    acc_next = acc_reg;
    dec_next = dec_reg;
    va_next = va_reg;
    ovl_next = ovl_reg;
    spd_tab_next = spd_tab_reg;
    trq_tab_next = trq_tab_reg;
    cfg_pulse = 1'b0;
    alarm_clr = 1'b0;
    if (wr_go && is_mapped(wr_addr)) begin
      case (wr_addr)
        A_CTRL: begin
          ctrl_next = nv & CTRL_STORE;
          cfg_pulse = wr_strb[C_CFG / 8] && wr_data[C_CFG];
          alarm_clr = wr_strb[C_ACLR / 8] && wr_data[C_ACLR];
        end
        A_ACC: acc_next = nv[15:0];
        A_DEC: dec_next = nv[15:0];
        A_VA: begin
          if (nv[31:9] != 23'h0 || nv[8:0] > VA_MAX) begin
            va_next = VA_MAX;
          end else if (nv[8:0] < VA_MIN) begin
            va_next = VA_MIN;
          end else begin
            va_next = nv[8:0];
          end
        end
        A_OVL: ovl_next = nv[15:0];
        default: begin
          if (wr_addr[5:4] == TAB_SPEED) begin
            spd_tab_next[wr_addr[3:2]] = nv[12:0];
          end else if (wr_addr[5:4] == TAB_TORQUE) begin
            trq_tab_next[wr_addr[3:2]] = nv[6:0];
          end
        end
      endcase
    end
  end

  // Millisecond tick, speed selection and run request decode
  always_comb begin
    ms_tick = ms_cnt_reg == 32'(CYC_PER_MS - 1);
    ms_cnt_next = ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
    set_spd = osv ? spd_tab_reg[osel] : spd_tab_reg[0];
    sel_trq = osv ? trq_tab_reg[osel] : trq_tab_reg[0];
    three = is_3wire(mode_reg);
    any_in = f_in || b_in;
    zero = ramp_spd == 13'h0;
    run_req = 1'b0;
    req_dir = dir_reg;
    kill = !pwr;
    if (three) begin
      run_req = f_in && b_in;
      kill = kill || (f_in && !b_in);
      if (d_in != dir_reg) begin
        case (mode_reg)
          MD_3W2: req_dir = (st_reg == ST_IDLE) ? d_in : dir_reg;
          MD_3W3: begin
            req_dir = d_in;
            kill = kill || (st_reg == ST_RUN && !zero);
          end
          default: req_dir = d_in;
        endcase
      end
    end else if (f_in && b_in) begin
      case (mode_reg)
        MD_2W2: run_req = 1'b1;
        MD_2W3: kill = 1'b1;
        default: run_req = 1'b0;
      endcase
    end else begin
      run_req = any_in;
      req_dir = b_in;
    end
  end

  // Run state machine
  always_comb begin
    st_next = st_reg;
    dir_next = dir_reg;
    settle_next = (settle_reg == 3'(SETTLE_CYC)) ? settle_reg : settle_reg + 3'h1;
    if (pwr && !pwr_reg) begin
      st_next = ST_INHIBIT;
      settle_next = 3'h0;
    end else begin
      case (st_reg)
        ST_INHIBIT: begin
          if (settle_reg == 3'(SETTLE_CYC) && (!ctrl_reg[C_PREV] || !any_in)) begin
            st_next = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (run_req && pwr && !alarm_reg && !kill) begin
            st_next = ST_RUN;
            dir_next = req_dir;
          end
        end
        ST_RUN: begin
          if (!run_req || kill || alarm_reg || req_dir != dir_reg) begin
            st_next = ST_DECEL;
          end
        end
        ST_DECEL: begin
          if (zero) begin
            st_next = ST_IDLE;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  // Settings that take effect at configure, power-up or standstill
  always_comb begin
    mode_next = mode_reg;
    keep_next = keep_reg;
    flt_next = flt_reg;
    if (cfg_pulse || (pwr && !pwr_reg)) begin
      mode_next = ctrl_reg[C_MODE +: 3];
      keep_next = ctrl_reg[C_KEEP];
    end
    if (st_reg != ST_RUN && st_reg != ST_DECEL && zero) begin
      flt_next = ctrl_reg[C_FLT +: 2];
    end
  end

  // Overload timing, attained speed, holding torque and brake
  always_comb begin
    target = (st_reg == ST_RUN) ? set_spd : 13'h0;
    spd_diff = (motor_speed > set_spd) ? motor_speed - set_spd : set_spd - motor_speed;
    ovc_next = ovc_reg;
    if (st_reg == ST_IDLE || load_factor_pct < (ctrl_reg[C_BIGM] ? OVL_LARGE_PCT
        : OVL_SMALL_PCT)) begin
      ovc_next = 16'h0;
    end else if (ms_tick && ovc_reg != ovl_reg) begin
      ovc_next = ovc_reg + 16'h1;
    end
    alarm_next = (ovc_reg == ovl_reg && ovc_reg != 16'h0) || (alarm_reg && !alarm_clr);
    va_out_next = st_reg == ST_RUN && spd_diff <= 13'(va_reg);
    hold_next = keep_reg && pwr && st_reg == ST_IDLE && zero
                && shaft_offset_deg >= KEEP_ANGLE_DEG;
    hlim_next = (sel_trq < KEEP_TRQ_PCT) ? sel_trq : KEEP_TRQ_PCT;
    brk_next = pwr && (st_reg == ST_RUN || st_reg == ST_DECEL || keep_reg);
  end

  // Ramp generator
  mdo_ramp #(.CYC_PER_MS(CYC_PER_MS)) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .target(target),
    .acc_time(acc_reg),
    .dec_time(dec_reg),
    .unit_set(ctrl_reg[C_UNIT] && mode_reg != MD_2W3 && mode_reg != MD_3W3),
    .kill(kill),
    .flt_sel(flt_reg),
    .ms_tick(ms_tick),
    .speed_out(ramp_spd)
  );

  // All registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      acc_reg <= ACC_DEF;
      dec_reg <= ACC_DEF;
      va_reg <= VA_DEF;
      ovl_reg <= OVL_DEF;
      for (int i = 0; i < 4; i++) begin
        spd_tab_reg[i] <= SPD_DEF;
        trq_tab_reg[i] <= TRQ_DEF;
      end
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
      st_reg <= ST_INHIBIT;
      mode_reg <= MD_2W1;
      keep_reg <= 1'b0;
      flt_reg <= FLT_NONE;
      dir_reg <= 1'b0;
      pwr_reg <= 1'b0;
      settle_reg <= 3'h0;
      ms_cnt_reg <= 32'h0;
      ovc_reg <= 16'h0;
      alarm_reg <= 1'b0;
      va_out_reg <= 1'b0;
      hold_reg <= 1'b0;
      hlim_reg <= 7'h0;
      brk_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      acc_reg <= acc_next;
      dec_reg <= dec_next;
      va_reg <= va_next;
      ovl_reg <= ovl_next;
      spd_tab_reg <= spd_tab_next;
      trq_tab_reg <= trq_tab_next;
      aw_got_reg <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg <= w_got_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      st_reg <= st_next;
      mode_reg <= mode_next;
      keep_reg <= keep_next;
      flt_reg <= flt_next;
      dir_reg <= dir_next;
      pwr_reg <= pwr;
      settle_reg <= settle_next;
      ms_cnt_reg <= ms_cnt_next;
      ovc_reg <= ovc_next;
      alarm_reg <= alarm_next;
      va_out_reg <= va_out_next;
      hold_reg <= hold_next;
      hlim_reg <= hlim_next;
      brk_reg <= brk_next;
    end
  end

  // Outputs
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign speed_command = ramp_spd;
  assign rotate_ccw = dir_reg;
  assign motor_run = st_reg == ST_RUN || st_reg == ST_DECEL;
  assign hold_torque_en = hold_reg;
  assign hold_torque_limit = hlim_reg;
  assign brake_release = brk_reg;
  assign speed_attained_output = va_out_reg;
  assign overload_alarm = alarm_reg;
endmodule // mdo_motor_ctrl

// ### dv/mdo_motor_ctrl_chk.sv
// Port checker for the motor drive operation block
`timescale 1ns/1ps
module mdo_motor_ctrl_chk
  import mdo_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Motor side
  input wire logic main_power_on,
  input wire logic [7:0] shaft_offset_deg,
  input wire logic [12:0] speed_command,
  input wire logic hold_torque_en,
  input wire logic [6:0] hold_torque_limit,
  input wire logic brake_release
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus steps and power loss
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  sequence s_power_gone;
    !main_power_on [*8];
  endsequence
  a_write_answer: assert property (s_wr_taken |=> bvalid) else $error("no write answer");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready) else $error("took write");
  a_read_answer: assert property (s_rd_taken |=> rvalid) else $error("no read answer");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  a_ar_refuse: assert property (rvalid |-> !arready) else $error("took read");
  a_power_stop: assert property (s_power_gone |-> speed_command == 13'h0 && !brake_release)
    else $error("running without power");
  a_keep_cap: assert property (hold_torque_en |-> hold_torque_limit <= KEEP_TRQ_PCT)
    else $error("holding torque too high");
  a_keep_angle: assert property ($rose(hold_torque_en) |-> $past(shaft_offset_deg) >= KEEP_ANGLE_DEG)
    else $error("hold below angle");
endmodule // mdo_motor_ctrl_chk

// ### dv/mdo_motor_model.sv
// Behavioural motor that follows the speed command
`timescale 1ns/1ps
module mdo_motor_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Drive and pace
  input wire logic [12:0] speed_command,
  input wire logic slow,
  // Feedback
  output logic [12:0] motor_speed
);
  // Shaft follows at once, or one r/min per cycle when slow
  always_ff @(posedge aclk) begin
    if (!aresetn || !slow || motor_speed == speed_command)
      motor_speed <= aresetn ? speed_command : 13'h0;
    else if (motor_speed < speed_command)
      motor_speed <= motor_speed + 13'h1;
    else
      motor_speed <= motor_speed - 13'h1;
  end
endmodule // mdo_motor_model

// ### dv/mdo_motor_ctrl_tb_top.sv
// Bench for the motor drive operation block
`timescale 1ns/1ps
module mdo_motor_ctrl_tb_top;
  import mdo_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, shaft_offset_deg = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic forward_run_input = 1'b0, backward_run_input = 1'b0, rotation_direction_input = 1'b0;
  logic main_power_on = 1'b1, op_select_valid = 1'b0, slow = 1'b1;
  logic [1:0] op_select = 2'h0;
  logic [8:0] load_factor_pct = 9'h0;
  logic awready, wready, bvalid, arready, rvalid, rotate_ccw, motor_run, hold_torque_en;
  logic brake_release, speed_attained_output, overload_alarm;
  logic [1:0] bresp, rresp;
  logic [1:0] wr_resp;
  logic [31:0] rdata;
  logic [12:0] motor_speed, speed_command;
  logic [6:0] hold_torque_limit;
  int errors = 0;
  int num_checks = 0;
  always #2 aclk = ~aclk;
  mdo_motor_ctrl #(.CYC_PER_MS(50)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .forward_run_input, .backward_run_input,
    .rotation_direction_input, .main_power_on, .op_select_valid, .op_select, .motor_speed,
    .load_factor_pct, .shaft_offset_deg, .speed_command, .rotate_ccw, .motor_run,
    .hold_torque_en, .hold_torque_limit, .brake_release, .speed_attained_output,
    .overload_alarm);
  mdo_motor_model u_motor (.aclk, .aresetn, .speed_command, .slow, .motor_speed);
  // Comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, d);
    chk({30'h0, rresp}, {30'h0, r});
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Pin helpers
  task automatic pwr();
    main_power_on <= 1'b0;
    repeat (10) @(posedge aclk);
    main_power_on <= 1'b1;
    repeat (20) @(posedge aclk);
  endtask
  task automatic wait_run(input logic want, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (motor_run === want) break;
    end
    chk({31'h0, motor_run}, {31'h0, want});
  endtask
  task automatic wait_spd(input logic [12:0] v, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (speed_command === v) break;
    end
    chk({19'h0, speed_command}, {19'h0, v});
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_CTRL, CTRL_RST, RESP_OKAY);
    rd(A_VA, {23'h0, VA_DEF}, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h5);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    wr(A_VA, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
    rd(A_VA, 32'h1, RESP_OKAY);
    wr(A_VA, 32'h1ff);
    rd(A_VA, {23'h0, VA_MAX}, RESP_OKAY);
    wr(A_VA, 32'h14);
    wr(A_TAB_LO, 32'h64);
    wr(8'h30, 32'h1e);
    wr(A_ACC, 32'h1);
    wr(A_DEC, 32'h1);
    wr(A_OVL, 32'h2);
    forward_run_input <= 1'b1;
    pwr();
    chk({31'h0, motor_run}, 32'h0);
    wr(A_CTRL, 32'h0);
    pwr();
    wait_run(1'b1, 50);
    wait_spd(13'h64, 5000);
    repeat (200) @(posedge aclk);
    chk({31'h0, speed_attained_output}, 32'h1);
    backward_run_input <= 1'b1;
    wait_run(1'b0, 2000);
    forward_run_input <= 1'b0;
    backward_run_input <= 1'b0;
    wr(A_CTRL, 32'h2);
    wr(A_CTRL, 32'h1_0002);
    shaft_offset_deg <= 8'h14;
    repeat (200) @(posedge aclk);
    chk({31'h0, hold_torque_en}, 32'h1);
    chk({25'h0, hold_torque_limit}, 32'h1e);
    chk({31'h0, brake_release}, 32'h1);
    shaft_offset_deg <= 8'h0;
    wr(A_CTRL, 32'h300);
    wr(A_CTRL, 32'h1_0300);
    slow <= 1'b0;
    forward_run_input <= 1'b1;
    wait_spd(13'h64, 5000);
    backward_run_input <= 1'b1;
    repeat (10) @(posedge aclk);
    chk({19'h0, speed_command}, 32'h0);
    forward_run_input <= 1'b0;
    backward_run_input <= 1'b0;
    wr(A_CTRL, 32'h100);
    wr(A_CTRL, 32'h1_0100);
    forward_run_input <= 1'b1;
    repeat (20) @(posedge aclk);
    chk({31'h0, motor_run}, 32'h0);
    backward_run_input <= 1'b1;
    wait_run(1'b1, 50);
    rotation_direction_input <= 1'b1;
    repeat (200) @(posedge aclk);
    chk({31'h0, rotate_ccw}, 32'h1);
    load_factor_pct <= OVL_SMALL_PCT;
    repeat (300) @(posedge aclk);
    chk({31'h0, overload_alarm}, 32'h1);
    wr(A_CTRL, 32'h2_0100);
    chk({31'h0, overload_alarm}, 32'h0);
    main_power_on <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({19'h0, speed_command}, 32'h0);
    tally_and_finish();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end
endmodule // mdo_motor_ctrl_tb_top
bind mdo_motor_ctrl mdo_motor_ctrl_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .main_power_on,
  .shaft_offset_deg, .speed_command, .hold_torque_en, .hold_torque_limit, .brake_release);
